// [logic/scad_decoder.sv]
// Function
// - subtract reg/reg, 001010dw plus addressing byte, takes 2 clocks
// - subtract 0010100w with addressing byte takes 7 clocks in memory modes; register mode decodes as reg/reg, 2 clocks
// - subtract 0010101w with addressing byte takes 6 clocks in memory modes; register mode decodes as reg/reg, 2 clocks
// - 100000sw with middle field 101 is immediate subtract, 2 reg or 7 memory
// - short accumulator subtract 0010110w plus immediate takes 2 clocks
// - borrow subtract reg/reg 000110dw takes 2 clocks
// - borrow subtract 0001100w with addressing byte takes 7 clocks in memory modes; register mode decodes as reg/reg, 2 clocks
// - borrow subtract 0001101w with addressing byte takes 6 clocks in memory modes; register mode decodes as reg/reg, 2 clocks
// - 100000sw with middle field 011 is immediate borrow subtract, 2 or 7
// - short accumulator borrow subtract 0001110w plus immediate takes 2 clocks
// - step down 1111111w field 001 takes 2/6; short 01001rrr takes 2
// - compare 0011100w with addressing byte takes 5 clocks
// - compare 0011101w with addressing byte takes 6 clocks
// - 100000sw with middle field 111 is immediate compare, 2 reg or 5 memory
// - short accumulator compare 0011110w plus immediate takes 2 clocks
// - opcode 00110111 is ascii fix after add, 4 clocks
// - opcode 00111111 is ascii fix after minus, 4 clocks
// - opcode 00100111 is packed fix after add, 4 clocks
// - opcode 00101111 is packed fix after minus, 4 clocks
`timescale 1ns/1ps
`include "scad_regs.svh"
module scad_decoder (
	input  wire logic                 i_mclk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_valid,
	input  scad_pkg::scad_fetch_t     i_fetch,
	input  wire logic                 i_exec_ready,
	output logic                      o_ready,
	output logic                      o_valid,
	output scad_pkg::scad_decode_t    o_decode,
	output logic                      o_unknown,
	output logic                      o_busy,
	output logic                      o_done
);
	import scad_pkg::*;

	scad_decode_t dec_d;
	scad_decode_t dec_q;
	logic         unknown_d;
	logic         unknown_q;
	scad_state_t  state_q;
	logic         take;
	logic         cnt_busy;
	logic         cnt_last;
	logic [7:0]   opc;
	logic [1:0]   mod_f;
	logic [2:0]   mid_f;
	logic         mem_op;
	scad_size_t   wide_size;
	logic         grp_imm;
	logic         grp_step;
	logic         step_short;

	assign opc   = i_fetch.opcode;
	assign mod_f = i_fetch.modrm[7:6];
	assign mid_f = i_fetch.modrm[5:3];
	assign mem_op = (mod_f != `SCAD_MOD_REG);
	assign wide_size = i_fetch.op32 ? SCAD_SZ_DWORD : SCAD_SZ_WORD;
	// shared opcode prefixes where the middle field picks the operation; the short step prefix carries a register in its low bits instead
	assign grp_imm    = (opc[7:2] == `SCAD_OP6_GRP_IMM);
	assign grp_step   = (opc[7:1] == `SCAD_OP7_GRP_STEP) && (mid_f == `SCAD_MID_STEP);
	assign step_short = (opc[7:3] == `SCAD_OP5_STEP_SHORT);

	// new instruction only accepted once the previous result has been handed over
	assign o_ready = (state_q == SCAD_ST_IDLE);
	assign take    = i_valid && o_ready;

	always_comb begin
		dec_d = '0;
		unknown_d = 1'b0;
		dec_d.op = SCAD_OP_NONE;
		dec_d.size = opc[`SCAD_BIT_SIZE] ? wide_size : SCAD_SZ_BYTE;
		dec_d.clocks = `SCAD_CLK_2;
		if (opc[7:2] == `SCAD_OP6_MINUS_RR && !mem_op) begin
			dec_d.op = SCAD_OP_MINUS;
			dec_d.has_modrm = 1'b1;
			dec_d.src_first = opc[`SCAD_BIT_DIR];
			dec_d.clocks = `SCAD_CLK_2;
		end else if (opc[7:1] == `SCAD_OP7_MINUS_RM) begin
			dec_d.op = SCAD_OP_MINUS;
			dec_d.has_modrm = 1'b1;
			dec_d.mem_operand = 1'b1;
			dec_d.clocks = `SCAD_CLK_7;
		end else if (opc[7:1] == `SCAD_OP7_MINUS_MR) begin
			dec_d.op = SCAD_OP_MINUS;
			dec_d.has_modrm = 1'b1;
			dec_d.mem_operand = 1'b1;
			dec_d.src_first = 1'b1;
			dec_d.clocks = `SCAD_CLK_6;
		end else if (opc[7:1] == `SCAD_OP7_MINUS_ACC) begin
			dec_d.op = SCAD_OP_MINUS;
			dec_d.imm_follows = 1'b1;
			dec_d.clocks = `SCAD_CLK_2;
		end else if (opc[7:2] == `SCAD_OP6_BORROW_RR && !mem_op) begin
			dec_d.op = SCAD_OP_BORROW;
			dec_d.has_modrm = 1'b1;
			dec_d.src_first = opc[`SCAD_BIT_DIR];
			dec_d.clocks = `SCAD_CLK_2;
		end else if (opc[7:1] == `SCAD_OP7_BORROW_RM) begin
			dec_d.op = SCAD_OP_BORROW;
			dec_d.has_modrm = 1'b1;
			dec_d.mem_operand = 1'b1;
			dec_d.clocks = `SCAD_CLK_7;
		end else if (opc[7:1] == `SCAD_OP7_BORROW_MR) begin
			dec_d.op = SCAD_OP_BORROW;
			dec_d.has_modrm = 1'b1;
			dec_d.mem_operand = 1'b1;
			dec_d.src_first = 1'b1;
			dec_d.clocks = `SCAD_CLK_6;
		end else if (opc[7:1] == `SCAD_OP7_BORROW_ACC) begin
			dec_d.op = SCAD_OP_BORROW;
			dec_d.imm_follows = 1'b1;
			dec_d.clocks = `SCAD_CLK_2;
		end else if (grp_imm && mid_f == `SCAD_MID_MINUS) begin
			dec_d.op = SCAD_OP_MINUS;
			dec_d.has_modrm = 1'b1;
			dec_d.imm_follows = 1'b1;
			dec_d.imm_sext = opc[`SCAD_BIT_EXT];
			dec_d.mem_operand = mem_op;
			dec_d.clocks = mem_op ? `SCAD_CLK_7 : `SCAD_CLK_2;
		end else if (grp_imm && mid_f == `SCAD_MID_BORROW) begin
			dec_d.op = SCAD_OP_BORROW;
			dec_d.has_modrm = 1'b1;
			dec_d.imm_follows = 1'b1;
			dec_d.imm_sext = opc[`SCAD_BIT_EXT];
			dec_d.mem_operand = mem_op;
			dec_d.clocks = mem_op ? `SCAD_CLK_7 : `SCAD_CLK_2;
		end else if (grp_imm && mid_f == `SCAD_MID_CMP) begin
			dec_d.op = SCAD_OP_COMPARE;
			dec_d.has_modrm = 1'b1;
			dec_d.imm_follows = 1'b1;
			dec_d.imm_sext = opc[`SCAD_BIT_EXT];
			dec_d.mem_operand = mem_op;
			dec_d.clocks = mem_op ? `SCAD_CLK_5 : `SCAD_CLK_2;
		end else if (grp_step) begin
			dec_d.op = SCAD_OP_STEP_DOWN;
			dec_d.has_modrm = 1'b1;
			dec_d.mem_operand = mem_op;
			dec_d.clocks = mem_op ? `SCAD_CLK_6 : `SCAD_CLK_2;
		end else if (step_short) begin
			dec_d.op = SCAD_OP_STEP_DOWN;
			dec_d.size = wide_size; // short form has no size bit
			dec_d.short_reg = opc[2:0];
			dec_d.clocks = `SCAD_CLK_2;
		end else if (opc[7:1] == `SCAD_OP7_CMP_MR) begin
			dec_d.op = SCAD_OP_COMPARE;
			dec_d.has_modrm = 1'b1;
			dec_d.mem_operand = 1'b1;
			dec_d.clocks = `SCAD_CLK_5;
		end else if (opc[7:1] == `SCAD_OP7_CMP_RM) begin
			dec_d.op = SCAD_OP_COMPARE;
			dec_d.has_modrm = 1'b1;
			dec_d.mem_operand = 1'b1;
			dec_d.src_first = 1'b1;
			dec_d.clocks = `SCAD_CLK_6;
		end else if (opc[7:1] == `SCAD_OP7_CMP_ACC) begin
			dec_d.op = SCAD_OP_COMPARE;
			dec_d.imm_follows = 1'b1;
			dec_d.clocks = `SCAD_CLK_2;
		end else if (opc == `SCAD_OP8_ASCII_ADD) begin
			dec_d.op = SCAD_OP_ASCII_ADD;
			dec_d.size = SCAD_SZ_BYTE;
			dec_d.clocks = `SCAD_CLK_4;
		end else if (opc == `SCAD_OP8_ASCII_MINUS) begin
			dec_d.op = SCAD_OP_ASCII_MINUS;
			dec_d.size = SCAD_SZ_BYTE;
			dec_d.clocks = `SCAD_CLK_4;
		end else if (opc == `SCAD_OP8_PACKED_ADD) begin
			dec_d.op = SCAD_OP_PACKED_ADD;
			dec_d.size = SCAD_SZ_BYTE;
			dec_d.clocks = `SCAD_CLK_4;
		end else if (opc == `SCAD_OP8_PACKED_MINUS) begin
			dec_d.op = SCAD_OP_PACKED_MINUS;
			dec_d.size = SCAD_SZ_BYTE;
			dec_d.clocks = `SCAD_CLK_4;
		end else begin
			// outside this group: flagged so another decoder can claim it
			unknown_d = 1'b1;
			dec_d.clocks = `SCAD_CLK_2;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dec_q <= '0;
		end else if (take) begin
			dec_q <= dec_d;
		end
	end

	// foreign opcode flag kept apart so another decoder can watch it alone
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			unknown_q <= 1'b0;
		end else if (take) begin
			unknown_q <= unknown_d;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= SCAD_ST_IDLE;
		end else begin
			case (state_q)
				SCAD_ST_IDLE: begin
					if (take) begin
						state_q <= SCAD_ST_EXEC;
					end
				end
				SCAD_ST_EXEC: begin
					if (cnt_last) begin
						state_q <= SCAD_ST_DONE;
					end else if (!cnt_busy) begin
						// a zero count would otherwise strand the fetch side
						state_q <= SCAD_ST_DONE;
					end
				end
				SCAD_ST_DONE: begin
					if (i_exec_ready) begin
						state_q <= SCAD_ST_IDLE;
					end
				end
				default: begin
					state_q <= SCAD_ST_IDLE;
				end
			endcase
		end
	end

	// counter loaded with the decoded count; exec lasts exactly that many clocks
	scad_clock_counter u_counter (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_load  (take),
		.i_count (dec_d.clocks),
		.o_busy  (cnt_busy),
		.o_last  (cnt_last)
	);

	assign o_decode  = dec_q;
	assign o_unknown = unknown_q;
	assign o_busy    = (state_q == SCAD_ST_EXEC);
	assign o_valid   = (state_q == SCAD_ST_DONE);
	assign o_done    = (state_q == SCAD_ST_DONE) && i_exec_ready;

endmodule : scad_decoder

// [pkg/scad_regs.svh]
// opcode patterns, field positions and clock counts for the subtract/compare/adjust decoder
`ifndef SCAD_REGS_SVH
`define SCAD_REGS_SVH

// opcode byte patterns (upper bits, compared after shifting)
`define SCAD_OP6_MINUS_RR      6'h0A
`define SCAD_OP7_MINUS_RM      7'h14
`define SCAD_OP7_MINUS_MR      7'h15
`define SCAD_OP7_MINUS_ACC     7'h16
`define SCAD_OP6_BORROW_RR     6'h06
`define SCAD_OP7_BORROW_RM     7'h0C
`define SCAD_OP7_BORROW_MR     7'h0D
`define SCAD_OP7_BORROW_ACC    7'h0E
`define SCAD_OP6_GRP_IMM       6'h20
`define SCAD_OP7_GRP_STEP      7'h7F
`define SCAD_OP5_STEP_SHORT    5'h09
`define SCAD_OP7_CMP_MR        7'h1C
`define SCAD_OP7_CMP_RM        7'h1D
`define SCAD_OP7_CMP_ACC       7'h1E
`define SCAD_OP8_ASCII_ADD     8'h37
`define SCAD_OP8_ASCII_MINUS   8'h3F
`define SCAD_OP8_PACKED_ADD    8'h27
`define SCAD_OP8_PACKED_MINUS  8'h2F

// addressing byte middle field selectors and mod field register value
`define SCAD_MID_MINUS         3'h5
`define SCAD_MID_BORROW        3'h3
`define SCAD_MID_CMP           3'h7
`define SCAD_MID_STEP          3'h1
`define SCAD_MOD_REG           2'h3

// field positions
`define SCAD_BIT_SIZE          0
`define SCAD_BIT_DIR           1
`define SCAD_BIT_EXT           1

// execution clock counts
`define SCAD_CLK_2             4'h2
`define SCAD_CLK_4             4'h4
`define SCAD_CLK_5             4'h5
`define SCAD_CLK_6             4'h6
`define SCAD_CLK_7             4'h7

`endif

// [pkg/scad_pkg.sv]
// types shared by the subtract/compare/adjust decoder
package scad_pkg;

	typedef enum logic [3:0] {
		SCAD_OP_NONE          = 4'b0000,
		SCAD_OP_MINUS         = 4'b0001,
		SCAD_OP_BORROW        = 4'b0010,
		SCAD_OP_STEP_DOWN     = 4'b0011,
		SCAD_OP_COMPARE       = 4'b0100,
		SCAD_OP_ASCII_ADD     = 4'b0101,
		SCAD_OP_ASCII_MINUS   = 4'b0110,
		SCAD_OP_PACKED_ADD    = 4'b0111,
		SCAD_OP_PACKED_MINUS  = 4'b1000
	} scad_op_t;

	typedef enum logic [1:0] {
		SCAD_SZ_BYTE  = 2'b00,
		SCAD_SZ_WORD  = 2'b01,
		SCAD_SZ_DWORD = 2'b10
	} scad_size_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] modrm;
		logic       op32;
	} scad_fetch_t;

	typedef struct packed {
		scad_op_t   op;
		scad_size_t size;
		logic       mem_operand;
		logic       src_first;
		logic       imm_follows;
		logic       imm_sext;
		logic       has_modrm;
		logic [2:0] short_reg;
		logic [3:0] clocks;
	} scad_decode_t;

	typedef enum logic [1:0] {
		SCAD_ST_IDLE = 2'b00,
		SCAD_ST_EXEC = 2'b01,
		SCAD_ST_DONE = 2'b10
	} scad_state_t;

endpackage : scad_pkg

// [logic/scad_clock_counter.sv]
// down-counter that times the execution of one decoded instruction
`timescale 1ns/1ps
module scad_clock_counter (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_load,
	input  wire logic [3:0] i_count,
	output logic            o_busy,
	output logic            o_last
);
	logic [3:0] remain_q;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			remain_q <= 4'h0;
		end else if (i_load) begin
			remain_q <= i_count;
		end else if (remain_q != 4'h0) begin
			remain_q <= remain_q - 4'h1;
		end
	end

	assign o_busy = (remain_q != 4'h0);
	// final execution clock is the one that still sees the count at one
	assign o_last = (remain_q == 4'h1);
endmodule : scad_clock_counter

// [tb/scad_decoder_sva.sv]
// port-level assertions for the subtract/compare/adjust decoder
`timescale 1ns/1ps
module scad_decoder_sva (
	input  wire logic            i_mclk,
	input  wire logic            i_rst_n,
	input  wire logic            i_valid,
	input  scad_pkg::scad_fetch_t  i_fetch,
	input  wire logic            i_exec_ready,
	input  wire logic            o_ready,
	input  wire logic            o_valid,
	input  scad_pkg::scad_decode_t o_decode,
	input  wire logic            o_unknown,
	input  wire logic            o_busy,
	input  wire logic            o_done
);
	import scad_pkg::*;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	logic [3:0] busy_n_q;
	wire logic  wide_grp = o_decode.op inside {SCAD_OP_MINUS, SCAD_OP_BORROW, SCAD_OP_COMPARE};
	// busy cycles since the last take, compared with the decoded count
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			busy_n_q <= 4'h0;
		else if (i_valid && o_ready)
			busy_n_q <= 4'h0;
		else if (o_busy)
			busy_n_q <= busy_n_q + 4'h1;
	end
	property p_busy_len; $rose(o_valid) |-> busy_n_q == o_decode.clocks; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length differs from clocks");
	property p_take; i_valid && o_ready |=> o_busy && !o_ready; endproperty
	a_take: assert property (p_take) else $error("take did not start execution");
	property p_min2; $rose(o_busy) |-> o_busy [*2]; endproperty
	a_min2: assert property (p_min2) else $error("execution shorter than two clocks");
	property p_bound; $rose(o_busy) |-> ##[2:7] o_valid; endproperty
	a_bound: assert property (p_bound) else $error("result late");
	property p_adjust;
		o_busy && o_decode.op inside {[SCAD_OP_ASCII_ADD:SCAD_OP_PACKED_MINUS]}
			|-> o_decode.clocks == 4'h4 && o_decode.size == SCAD_SZ_BYTE;
	endproperty
	a_adjust: assert property (p_adjust) else $error("adjust op timing wrong");
	property p_reg_low;
		o_busy && !o_decode.mem_operand && o_decode.op inside {SCAD_OP_MINUS, SCAD_OP_BORROW, SCAD_OP_STEP_DOWN}
			|-> o_decode.clocks == 4'h2;
	endproperty
	a_reg_low: assert property (p_reg_low) else $error("register form not two clocks");
	property p_cmp; o_busy && o_decode.op == SCAD_OP_COMPARE |-> o_decode.clocks inside {4'h2, 4'h5, 4'h6}; endproperty
	a_cmp: assert property (p_cmp) else $error("compare count wrong");
	property p_byte; $rose(o_busy) && wide_grp && !$past(i_fetch.opcode[0]) |-> o_decode.size == SCAD_SZ_BYTE; endproperty
	a_byte: assert property (p_byte) else $error("size bit clear not byte");
	property p_wide;
		$rose(o_busy) && wide_grp && $past(i_fetch.opcode[0])
			|-> o_decode.size == ($past(i_fetch.op32) ? SCAD_SZ_DWORD : SCAD_SZ_WORD);
	endproperty
	a_wide: assert property (p_wide) else $error("size bit set wrong width");
	property p_stand; o_valid && !i_exec_ready |=> o_valid && $stable(o_decode); endproperty
	a_stand: assert property (p_stand) else $error("result dropped while stalled");
	property p_done; o_valid && i_exec_ready |-> o_done ##1 !o_valid; endproperty
	a_done: assert property (p_done) else $error("handover not pulsed");
	property p_unknown; o_unknown |-> o_decode.op == SCAD_OP_NONE && o_decode.clocks == 4'h2; endproperty
	a_unknown: assert property (p_unknown) else $error("unknown opcode decode wrong");
	c_stall: cover property (o_valid && !i_exec_ready);
	c_unknown: cover property (o_unknown && o_done);
	c_mem: cover property (o_done && o_decode.mem_operand);
	c_adjust: cover property (o_done && o_decode.clocks == 4'h4);
endmodule : scad_decoder_sva

bind scad_decoder scad_decoder_sva scad_decoder_sva_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(i_valid),
	.i_fetch(i_fetch), .i_exec_ready(i_exec_ready), .o_ready(o_ready), .o_valid(o_valid), .o_decode(o_decode),
	.o_unknown(o_unknown), .o_busy(o_busy), .o_done(o_done));

// [tb/scad_exec_model.sv]
// execution datapath stand-in that takes a result after a set stall
`timescale 1ns/1ps
module scad_exec_model (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_n,
	input  wire logic       i_result_valid,
	input  wire logic [3:0] i_stall,
	output logic            o_accept
);
	logic [3:0] wait_q;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n)
			wait_q <= 4'h0;
		else if (i_result_valid && !o_accept)
			wait_q <= wait_q + 4'h1;
		else
			wait_q <= 4'h0;
	end
	// never ready ahead of a result, so a stall really holds the decoder
	assign o_accept = i_result_valid && (wait_q >= i_stall);
endmodule : scad_exec_model

// [tb/tb_top.sv]
// self-checking bench for the subtract/compare/adjust decoder
`timescale 1ns/1ps
module tb_top;
	import scad_pkg::*;
	logic         i_mclk;
	logic         i_rst_n;
	logic         i_valid;
	logic         i_exec_ready;
	scad_fetch_t  i_fetch;
	scad_decode_t o_decode;
	logic         o_ready, o_valid, o_unknown, o_busy, o_done;
	logic [3:0]   stall;
	logic [35:0]  r;
	int           nb;
	int           n_mismatch = 0;
	int           n_tests = 0;
	// opcode, addressing byte, op32, op, size, memory, clocks
	logic [35:0]  rows [25] = '{
		36'h2_BC11_1202, 36'h2_8060_1017, 36'h2_B460_1116,
		36'h8_1E81_1202, 36'h8_32E0_1117, 36'h2_C000_1002,
		36'h1_AC00_2002, 36'h1_9001_2217, 36'h1_A800_2016,
		36'h8_0D80_2002, 36'h8_1181_2217, 36'h1_D000_2102,
		36'hF_EC80_3002, 36'hF_F080_3116, 36'h4_B001_3202,
		36'h3_8000_4015, 36'h3_B400_4116, 36'h8_3F81_4202,
		36'h8_0380_4015, 36'h3_D001_4202, 36'h3_7000_5004,
		36'h3_F000_6004, 36'h2_7000_7004, 36'h2_F000_8004,
		36'h9_0000_0002};

	scad_decoder scad_decoder_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_fetch(i_fetch),
		.i_exec_ready(i_exec_ready), .o_ready(o_ready), .o_valid(o_valid), .o_decode(o_decode),
		.o_unknown(o_unknown), .o_busy(o_busy), .o_done(o_done));
	scad_exec_model scad_exec_model_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_result_valid(o_valid),
		.i_stall(stall), .o_accept(i_exec_ready));

	always #12.5 i_mclk = ~i_mclk;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic issue(input logic [7:0] opc, input logic [7:0] mrm, input logic o32, output int n);
		n = 0;
		while (o_ready !== 1'b1)
			@(posedge i_mclk) #2;
		i_valid = 1'b1;
		i_fetch = {opc, mrm, o32};
		@(posedge i_mclk) #2;
		i_valid = 1'b0;
		while (o_valid !== 1'b1 && n < 20) begin
			n += int'(o_busy === 1'b1);
			@(posedge i_mclk) #2;
		end
	endtask : issue

	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	initial begin
		#60000;
		n_mismatch++;
		wrap_up;
	end

	initial begin
		i_mclk = 1'b0;
		i_rst_n = 1'b0;
		i_valid = 1'b0;
		i_fetch = '0;
		stall = 4'h0;
		repeat (5) @(posedge i_mclk) #2;
		chk("ready in reset", 32'h1, o_ready);
		chk("decode in reset", 32'h0, {o_decode, o_valid, o_busy});
		i_rst_n = 1'b1;
		for (int k = 0; k < 25; k++) begin
			r = rows[k];
			issue(r[35:28], r[27:20], r[16], nb);
			chk("op", r[15:12], o_decode.op);
			chk("size", r[9:8], o_decode.size);
			chk("mem", r[4], o_decode.mem_operand);
			chk("clocks", r[3:0], o_decode.clocks);
			chk("busy cycles", r[3:0], nb);
			chk("short reg", (r[35:31] == 5'h09) ? r[30:28] : 3'h0, o_decode.short_reg);
			chk("imm follows", r[35:30] == 6'h20 || r[35:29] inside {7'h16, 7'h0E, 7'h1E}, o_decode.imm_follows);
			chk("unknown", r[15:12] == 4'h0, o_unknown);
			chk("done", 32'h1, o_done);
			$display("row %0d done", k);
		end
		// result held back by the datapath while a new opcode is offered
		stall = 4'h3;
		issue(8'h37, 8'h00, 1'b0, nb);
		i_valid = 1'b1;
		i_fetch = {8'h90, 8'h00, 1'b0};
		repeat (2) begin
			@(posedge i_mclk) #2;
			chk("ready stalled", 32'h0, {o_ready, ~o_valid});
			chk("op stalled", SCAD_OP_ASCII_ADD, o_decode.op);
		end
		i_valid = 1'b0;
		@(posedge i_mclk) #2;
		chk("done late", 32'h1, o_done);
		stall = 4'h0;
		$display("stall test done");
		// reset in mid execution
		@(posedge i_mclk) #2;
		i_valid = 1'b1;
		i_fetch = {8'hFF, 8'h08, 1'b0};
		@(posedge i_mclk) #2;
		i_valid = 1'b0;
		@(posedge i_mclk) #2;
		i_rst_n = 1'b0;
		#1;
		chk("reset mid run", 32'h1, {o_decode, o_valid, o_busy, o_unknown, o_ready});
		@(posedge i_mclk) #2;
		i_rst_n = 1'b1;
		issue(8'h2F, 8'h00, 1'b0, nb);
		chk("clocks after reset", 32'h4, o_decode.clocks);
		chk("busy after reset", 32'h4, nb);
		$display("reset test done");
		wrap_up;
	end
endmodule : tb_top
